// file: src/ipd_pkg.sv
/*
 Constants, types and helpers for the interrupt polarity and debounce block.
 Assumes a 20 MHz core clock and an APB master with 32-bit data.
*/
package ipd_pkg;

    // ==========================================================
    // Register map (index; byte address is four times it)
    localparam logic [7:0]  IDX_STATUS   = 8'h7f;
    localparam logic [7:0]  IDX_MASK     = 8'h80;
    localparam logic [7:0]  IDX_POL      = 8'h81;
    localparam logic [7:0]  IDX_DB       = 8'h82;
    localparam logic [7:0]  IDX_CLEAR    = 8'h83;
    localparam int          ADDR_W       = 12;

    // ==========================================================
    // Field layout and reset values
    localparam logic [15:0] SRC_FIELDS   = 16'h033f;
    localparam logic [15:0] POL_RST      = 16'h0000;
    localparam logic [15:0] DB_RST       = 16'h0000;
    localparam logic [15:0] MASK_RST     = 16'h033f;
    localparam logic [15:0] STATUS_RST   = 16'h0000;
    localparam int          SUMMARY_BIT  = 10;
    localparam int          PIN4_BIT     = 9;
    localparam int          SEQ_BIT      = 8;
    localparam int          PIN1_BIT     = 5;
    localparam int          IN8_BIT      = 4;
    localparam int          IN7_BIT      = 3;
    localparam int          LOCK_BIT     = 2;
    localparam int          SHORT_BIT    = 1;
    localparam int          DETECT_BIT   = 0;

    // ==========================================================
    // Timing
    localparam int          CLK_PERIOD_NS = 50;
    localparam int          DB_TIME_NS    = 1000;
    localparam int          DB_CYCLES     = (DB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          DB_CNT_W      = 5;
    localparam logic [4:0]  DB_LAST       = 5'(DB_CYCLES - 1);

    // ==========================================================
    // Types
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic        hit;
        logic [7:0]  idx;
        logic [15:0] wdata;
    } ipd_req_t;

    typedef enum logic [2:0] {
        PH_IDLE   = 3'b001,
        PH_SETUP  = 3'b010,
        PH_ACCESS = 3'b100
    } ipd_phase_t;

    // Eight sources packed low-first: detect, short, lock, in7, in8, pin1, seq, pin4
    function automatic logic [15:0] ipd_spread(input logic [7:0] s);
        return {6'h00, s[7], s[6], 2'h0, s[5:0]};
    endfunction

    function automatic logic [7:0] ipd_gather(input logic [15:0] r);
        return {r[PIN4_BIT], r[SEQ_BIT], r[5:0]};
    endfunction

endpackage

// file: src/ipd_debounce.sv
/*
 One-source debouncer with bypass.
 Assumes the level is already synchronous to clk.
*/
`timescale 1ns/100ps
module ipd_debounce import ipd_pkg::*; (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic enable,
    input  wire logic level,
    output logic      filtered
);

    // ==========================================================
    // Counter of consecutive cycles that differ from the output
    logic [DB_CNT_W-1:0] cnt_reg;
    logic [DB_CNT_W-1:0] cnt_next;
    logic                out_reg;
    logic                out_next;

    wire differs = level != out_reg;
    wire settled = cnt_reg == DB_LAST;

    // A glitch shorter than the window restarts the count
    assign cnt_next = (enable && differs && !settled) ? cnt_reg + 5'h01 : 5'h00;
    assign out_next = !enable ? level : ((differs && settled) ? level : out_reg);
    assign filtered = out_reg;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_reg <= 5'h00;
            out_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            out_reg <= out_next;
        end
    end

    a_db_settle: assert property (@(posedge clk) disable iff (!rstn)
        ($past(enable) && out_reg != $past(out_reg)) |-> $past(cnt_reg) == DB_LAST)
        else $error("debounced output moved before the window");

endmodule

// file: src/ipd_apb_port.sv
/*
 APB slave front end: phase tracking and request decode.
 Assumes an APB master; the slave never inserts wait states.
*/
`timescale 1ns/100ps
module ipd_apb_port import ipd_pkg::*; (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output ipd_req_t               req,
    output logic                   pready,
    output logic                   pslverr
);

    // ==========================================================
    // Phase tracking
    ipd_phase_t phase_reg;
    ipd_phase_t phase_next;

    always_comb begin
        case (phase_reg)
            PH_IDLE:   phase_next = (psel && !penable) ? PH_SETUP : PH_IDLE;
            PH_SETUP:  phase_next = PH_ACCESS;
            PH_ACCESS: phase_next = (psel && !penable) ? PH_SETUP : PH_IDLE;
            default:   phase_next = PH_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            phase_reg <= PH_IDLE;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // ==========================================================
    // Decode
    wire [7:0] idx     = paddr[9:2];
    wire       aligned = paddr[ADDR_W-1:10] == 2'h0 && paddr[1:0] == 2'h0;
    wire       hit     = aligned && idx >= IDX_STATUS && idx <= IDX_CLEAR;
    wire       access  = psel && penable;

    // Only an access that followed a setup cycle may write
    assign req.wr    = access && pwrite && hit && (phase_reg == PH_SETUP);
    assign req.rd    = psel && !penable && !pwrite;
    assign req.hit   = hit;
    assign req.idx   = idx;
    assign req.wdata = pwdata[15:0];
    assign pready    = 1'b1;
    assign pslverr   = access && !hit;

    a_err_unmapped: assert property (@(posedge clk) disable iff (!rstn)
        (psel && penable && !hit) |-> (pslverr && !req.wr))
        else $error("unmapped access not refused");

endmodule

// file: src/ipd_irq_cfg.sv
/*
 Interrupt flag logic with per-source polarity and debounce, behind APB.
 Assumes source levels synchronous to clk; software services irq.
*/
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
module ipd_irq_cfg import ipd_pkg::*; (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              pin4_level,
    input  wire logic              seq_busy,
    input  wire logic              pin1_level,
    input  wire logic              input8_level,
    input  wire logic              input7_level,
    input  wire logic              lock_reached,
    input  wire logic              bias_short,
    input  wire logic              bias_detect,
    output logic                   irq
);

    // ==========================================================
    // Bus front end
    ipd_req_t req;

    ipd_apb_port u_port (
        .clk     (clk),
        .rstn    (rstn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .req     (req),
        .pready  (pready),
        .pslverr (pslverr)
    );

    // ==========================================================
    // Registers
    logic [15:0] pol_reg;
    logic [15:0] pol_next;
    logic [15:0] db_reg;
    logic [15:0] db_next;
    logic [15:0] mask_reg;
    logic [15:0] mask_next;
    logic [15:0] status_reg;
    logic [15:0] status_next;
    logic        irq_reg;
    logic        irq_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    wire wr_pol    = req.wr && req.idx == IDX_POL;
    wire wr_db     = req.wr && req.idx == IDX_DB;
    wire wr_mask   = req.wr && req.idx == IDX_MASK;
    wire wr_clear  = req.wr && (req.idx == IDX_STATUS || req.idx == IDX_CLEAR);
    wire [15:0] wfield = req.wdata & SRC_FIELDS;

    assign pol_next  = wr_pol  ? wfield : pol_reg;
    assign db_next   = wr_db   ? wfield : db_reg;
    assign mask_next = wr_mask ? (req.wdata & SRC_FIELDS) : mask_reg;

    // ==========================================================
    // Source conditioning
    wire [7:0]  src_raw = {pin4_level, seq_busy, pin1_level, input8_level,
                           input7_level, lock_reached, bias_short, bias_detect};
    // Polarity one inverts, so busy/locked flag at zero and idle/unlocked at one
    wire [15:0] cond    = ipd_spread(src_raw) ^ pol_reg;
    wire [7:0]  cond8   = ipd_gather(cond);
    wire [7:0]  db8     = ipd_gather(db_reg);
    logic [7:0] filt8;

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_src
            ipd_debounce u_db (
                .clk      (clk),
                .rstn     (rstn),
                .enable   (db8[g]),
                .level    (cond8[g]),
                .filtered (filt8[g])
            );
        end
    endgenerate

    wire [15:0] filt = ipd_spread(filt8);

    // ==========================================================
    // Sticky flags; a set in the clearing cycle wins
    wire [15:0] clr_bits = wr_clear ? wfield : 16'h0000;

    assign status_next = (status_reg & ~clr_bits) | filt;
    assign irq_next    = |(status_next & ~mask_next);

    // ==========================================================
    // Read path
    wire summary = |status_reg;
    wire [15:0] status_view = status_reg | (16'h0001 << SUMMARY_BIT) & {16{summary}};
    wire [15:0] rsel =
        (req.idx == IDX_STATUS) ? status_view :
        (req.idx == IDX_MASK)   ? mask_reg    :
        (req.idx == IDX_POL)    ? pol_reg     :
        (req.idx == IDX_DB)     ? db_reg      : 16'h0000;

    // Loaded in the setup cycle so the access cycle needs no wait state
    assign rdata_next = req.rd ? ((req.hit) ? {16'h0000, rsel} : 32'h00000000) : rdata_reg;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pol_reg    <= POL_RST;
            db_reg     <= DB_RST;
            mask_reg   <= MASK_RST;
            status_reg <= STATUS_RST;
            irq_reg    <= 1'b0;
            rdata_reg  <= 32'h00000000;
        end else begin
            pol_reg    <= pol_next;
            db_reg     <= db_next;
            mask_reg   <= mask_next;
            status_reg <= status_next;
            irq_reg    <= irq_next;
            rdata_reg  <= rdata_next;
        end
    end

    assign prdata = rdata_reg;
    assign irq    = irq_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_flag_sticky: assert property (
        1'b1 |=> (($past(status_reg) & ~$past(clr_bits) & ~status_reg) == 16'h0000))
        else $error("flag dropped without a clear");

    a_set_wins: assert property (
        1'b1 |=> (($past(filt) & ~status_reg) == 16'h0000))
        else $error("raised source not flagged");

    a_clear_w1c: assert property (
        (wr_clear && !filt[SHORT_BIT] && wfield[SHORT_BIT]) |=> !status_reg[SHORT_BIT])
        else $error("write one did not clear flag");

    a_summary_or: assert property (
        (req.rd && req.hit && req.idx == IDX_STATUS) |=> prdata[SUMMARY_BIT] == |$past(status_reg))
        else $error("summary bit wrong");

    a_mask_reset: assert property (
        $rose(rstn) |-> (mask_reg == MASK_RST && pol_reg == POL_RST && db_reg == DB_RST))
        else $error("reset values wrong");

    a_irq_level: assert property (
        irq == |(status_reg & ~mask_reg))
        else $error("irq disagrees with unmasked flags");

    a_seq_polarity: assert property (
        (!db_reg[SEQ_BIT] && (seq_busy ^ pol_reg[SEQ_BIT])) |-> ##2 status_reg[SEQ_BIT])
        else $error("sequencer flag missed");

    a_lock_polarity: assert property (
        (!db_reg[LOCK_BIT] && (lock_reached ^ pol_reg[LOCK_BIT])) |-> ##2 status_reg[LOCK_BIT])
        else $error("lock flag missed");

    a_cfg_write: assert property (
        (psel && penable && pwrite && paddr == {2'h0, IDX_POL, 2'h0})
        |=> pol_reg == ($past(pwdata[15:0]) & SRC_FIELDS))
        else $error("polarity write not stored");

endmodule

// file: test/ipd_src_model.sv
/*
 Source-side model: the eight raw event levels seen by the block.
 Assumes the bench steers it with one command byte, synchronous to clk.
*/
`timescale 1ns/100ps
module ipd_src_model (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [7:0] cmd,
    output logic [7:0]      lv
);
    // ==========================================================
    // Levels move one edge after the command, like a real source
    always_ff @(posedge clk) begin
        if (!rstn) begin
            lv <= 8'h00;
        end else begin
            lv <= cmd;
        end
    end
endmodule

// file: test/tb_top.sv
/*
 Self-checking bench for the interrupt polarity and debounce block.
 Assumes the package constants and the source model beside it.
*/
`timescale 1ns/100ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin miscompares++; \
    $display("FAIL %s exp %h got %h", nm, e, s); end end
module tb_top import ipd_pkg::*;;
    logic        clk;
    logic        rstn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        err;
    logic        irq;
    logic [7:0]  cmd;
    logic [7:0]  lv;
    logic [7:0]  s;
    int          miscompares;
    int          n_tests;

    ipd_src_model SRC (.clk(clk), .rstn(rstn), .cmd(cmd), .lv(lv));

    ipd_irq_cfg DUT (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin4_level(lv[7]), .seq_busy(lv[6]), .pin1_level(lv[5]), .input8_level(lv[4]),
        .input7_level(lv[3]), .lock_reached(lv[2]), .bias_short(lv[1]), .bias_detect(lv[0]),
        .irq(irq));

    // ==========================================================
    // Bus and check helpers
    function automatic logic [31:0] st(input logic [7:0] v);
        return {16'h0000, 5'h00, |v, v[7:6], 2'h0, v[5:0]};
    endfunction

    task automatic bus(input logic w, input logic [7:0] idx, input logic [15:0] wd);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {16'h0000, wd};
        @(posedge clk);
        penable <= 1'b1;
        // Wait on pready itself; the watchdog ends a hang
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input string nm, input logic [7:0] idx, input logic [31:0] e);
        bus(1'b0, idx, 16'h0000);
        `CHK(nm, e, rd)
    endtask

    task automatic wr(input logic [7:0] idx, input logic [15:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ==========================================================
    // Clock, watchdog
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        #2000000;
        miscompares++;
        wrap_up();
    end

    // ==========================================================
    // Tests
    initial begin
        rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; cmd = 8'h00;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rchk("pol", IDX_POL, 32'h0);
        rchk("db", IDX_DB, 32'h0);
        rchk("mask", IDX_MASK, 32'h033f);
        rchk("stat", IDX_STATUS, 32'h0);
        `CHK("slverr_ok", 1'b0, err)
        rchk("unmapped", 8'hc0, 32'h0);
        `CHK("slverr", 1'b1, err)
        $display("test reset done");
        // Each source alone, active high; clear loses while still active
        for (int i = 0; i < 8; i++) begin
            s = 8'h01 << i;
            cmd <= s;
            repeat (4) @(posedge clk);
            wr(IDX_CLEAR, 16'h033f);
            rchk("high", IDX_STATUS, st(s));
            cmd <= 8'h00;
            repeat (4) @(posedge clk);
            rchk("stick", IDX_STATUS, st(s));
            wr(IDX_STATUS, 16'(st(s)));
            rchk("clr", IDX_STATUS, 32'h0);
        end
        $display("test source done");
        // Inverted polarity: absent condition flags every source
        wr(IDX_POL, 16'h033f);
        rchk("pol_rb", IDX_POL, 32'h033f);
        rchk("low", IDX_STATUS, st(8'hff));
        cmd <= 8'hff;
        repeat (4) @(posedge clk);
        wr(IDX_CLEAR, 16'h033f);
        rchk("low_clr", IDX_STATUS, 32'h0);
        cmd <= 8'h00;
        wr(IDX_POL, 16'h0000);
        // Levels fall while polarity is still inverted, so every source flags; drop those flags
        repeat (2) @(posedge clk);
        wr(IDX_CLEAR, 16'h033f);
        $display("test polarity done");
        // Sequencer flag against its mask bit
        cmd <= 8'h40;
        repeat (4) @(posedge clk);
        `CHK("irq_masked", 1'b0, irq)
        wr(IDX_MASK, 16'h02ff);
        rchk("mask_rb", IDX_MASK, 32'h023f);
        `CHK("irq_on", 1'b1, irq)
        rchk("seq_only", IDX_STATUS, st(8'h40));
        wr(IDX_MASK, 16'h033f);
        repeat (2) @(posedge clk);
        `CHK("irq_off", 1'b0, irq)
        cmd <= 8'h00;
        repeat (3) @(posedge clk);
        wr(IDX_CLEAR, 16'h033f);
        $display("test mask done");
        // Debounce: short glitch ignored, long level passes
        wr(IDX_DB, 16'h033f);
        rchk("db_rb", IDX_DB, 32'h033f);
        cmd <= 8'hff;
        repeat (10) @(posedge clk);
        cmd <= 8'h00;
        repeat (30) @(posedge clk);
        rchk("glitch", IDX_STATUS, 32'h0);
        cmd <= 8'hff;
        repeat (25) @(posedge clk);
        rchk("steady", IDX_STATUS, st(8'hff));
        cmd <= 8'h00;
        repeat (25) @(posedge clk);
        wr(IDX_STATUS, 16'h033f);
        rchk("db_clr", IDX_STATUS, 32'h0);
        $display("test debounce done");
        wrap_up();
    end
endmodule
